// File: gpls_cfg.svh
// Offsets, field positions, reset values and codes of the level-sense GPIO port
`ifndef GPLS_CFG_SVH
`define GPLS_CFG_SVH

`define GPLS_NPINS          32
`define GPLS_AW             12

`define GPLS_OFF_OUT        12'h504
`define GPLS_OFF_OUTSET     12'h508
`define GPLS_OFF_OUTCLR     12'h50c
`define GPLS_OFF_IN         12'h510
`define GPLS_OFF_DIR        12'h514
`define GPLS_OFF_DIRSET     12'h518
`define GPLS_OFF_DIRCLR     12'h51c
`define GPLS_OFF_LATCH      12'h520
`define GPLS_OFF_MODE       12'h524
`define GPLS_OFF_SETUP      12'h700
`define GPLS_SETUP_IDX_MASK 12'h07c
`define GPLS_SETUP_IDX_LSB  2
`define GPLS_SETUP_IDX_W    5

`define GPLS_SETUP_DIR      0
`define GPLS_SETUP_INDISC   1
`define GPLS_SETUP_PULL_LSB 2
`define GPLS_SETUP_DRV_LSB  8
`define GPLS_SETUP_SNS_LSB  16
`define GPLS_SETUP_MASK     32'h0003070f
`define GPLS_SETUP_RESET    32'h00000002

`define GPLS_PULL_DOWN      2'h1
`define GPLS_PULL_UP        2'h3

`define GPLS_MODE_BIT       0

`define GPLS_RESP_OKAY      2'h0
`define GPLS_RESP_SLVERR    2'h2

`endif

// File: gpls_pkg.sv
// Types shared by the level-sense GPIO port
package gpls_pkg;

	typedef enum logic [1:0] {
		GPLS_SENSE_OFF  = 2'h0,
		GPLS_SENSE_HIGH = 2'h2,
		GPLS_SENSE_LOW  = 2'h3
	} gpls_sense_e;

	typedef logic [31:0] gpls_word_t;

endpackage

// File: gpls_sync.sv
// Three-flop pin input synchroniser with agreement filter
`timescale 1ns/1ps
module gpls_sync #(
	parameter int W = 32
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] val;
	} gpls_sync_s;

	gpls_sync_s q;
	gpls_sync_s d;

	always_comb begin
		d = q;
		d.s1 = async_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		// Only bits on which stages two and three agree may change
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.val[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign sync_out = q.val;

endmodule

// File: gpls_port.sv
// Level-sense GPIO port with sticky match latch and AXI4-Lite registers
//
// Overview of operation
// - Up to 32 pins, each configured by its own indexed pin_setup register.
// - pin_setup holds direction, drive, pulls, sensing and input disconnect.
// - pin_setup contents survive low-power states; only cfg reset clears them.
// - Per-pin level_trigger_select picks high-level or low-level sensing.
// - Enabled pin at its selected level drives its own level_match_signal.
// - Default mode ORs all pin match signals into the port detect output.
// - Sensing and detect keep working while running and in deep sleep.
// - Level already present at enable raises the match at once.
// - port_wake_event fires when detect rises from low.
// - Rising match on pin x sets bit x of sticky_match_register.
// - Clearing a bit whose pin still matches leaves the bit set.
// - Sticky bits clear only by writing one; falling match never clears.
// - latched_match_signal is high while any sticky bit is one, save for the one cycle after a clear write that hits a set bit.
// - Bits left after a clear give a fresh rising edge on latched_match_signal.
// - sticky_match_register is readable at any time in either detect mode.
// - match_source_select picks pin OR or latched_match_signal for detect.
// - Disconnected input buffer hides the pin from input register and sensing.
// - Peripherals may override pin output and config and read its input.
// - Detect output serves the power unit as a deep-sleep wake source.
`timescale 1ns/1ps
`include "gpls_cfg.svh"
module gpls_port #(
	parameter int NPINS = `GPLS_NPINS,
	parameter int AW    = `GPLS_AW
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               cfg_resetn,
	input  wire logic               ce,
	input  wire logic [AW-1:0]      s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [AW-1:0]      s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic [NPINS-1:0]   pin_in,
	output logic [NPINS-1:0]        pin_out,
	output logic [NPINS-1:0]        pin_oe,
	output logic [NPINS-1:0]        pin_pull_up,
	output logic [NPINS-1:0]        pin_pull_down,
	output logic [NPINS-1:0]        pin_in_en,
	output logic [3*NPINS-1:0]      pin_drive,
	input  wire logic [NPINS-1:0]   periph_ovr_en,
	input  wire logic [NPINS-1:0]   periph_out,
	input  wire logic [NPINS-1:0]   periph_oe,
	input  wire logic [NPINS-1:0]   periph_in_en,
	output logic [NPINS-1:0]        periph_in,
	input  wire logic               deep_sleep,
	output logic                    detect,
	output logic                    port_wake_event,
	output logic                    latched_match_signal,
	output logic                    wake_req
);

	typedef struct packed {
		logic [NPINS-1:0][31:0] setup;
		logic [NPINS-1:0]       drv;
		logic [NPINS-1:0]       dir;
		logic [NPINS-1:0]       latch;
		logic [NPINS-1:0]       in_v;
		logic                   mode;
		logic                   aw_ok;
		logic [AW-1:0]          aw_addr;
		logic                   w_ok;
		logic [31:0]            w_data;
		logic [3:0]             w_strb;
		logic                   awready;
		logic                   wready;
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   arready;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
		logic [NPINS-1:0]       p_out;
		logic [NPINS-1:0]       p_oe;
		logic [NPINS-1:0]       p_pu;
		logic [NPINS-1:0]       p_pd;
		logic [NPINS-1:0]       p_ien;
		logic [NPINS-1:0][2:0]  p_drv;
		logic                   detect;
		logic                   wake_ev;
		logic                   latched;
		logic                   wake_req;
	} gpls_port_s;

	gpls_port_s       q;
	gpls_port_s       d;
	gpls_port_s       rst_v;
	logic [NPINS-1:0] pin_sync;

	// Pin inputs cross into aclk here
	gpls_sync #(
		.W(NPINS)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 4; b++) begin
			m[8*b +: 8] = {8{strb[b]}};
		end
		return m;
	endfunction

	function automatic logic is_setup(input logic [AW-1:0] a);
		logic [AW-1:0] idx;
		idx = a & AW'(`GPLS_SETUP_IDX_MASK);
		return ((a & ~AW'(`GPLS_SETUP_IDX_MASK)) == AW'(`GPLS_OFF_SETUP))
			&& (int'(idx >> `GPLS_SETUP_IDX_LSB) < NPINS);
	endfunction

	function automatic logic [`GPLS_SETUP_IDX_W-1:0] setup_idx(input logic [AW-1:0] a);
		return a[`GPLS_SETUP_IDX_LSB +: `GPLS_SETUP_IDX_W];
	endfunction

	function automatic logic [31:0] widen(input logic [NPINS-1:0] v);
		return 32'(v);
	endfunction

	function automatic logic [NPINS-1:0] narrow(input logic [31:0] v);
		return v[NPINS-1:0];
	endfunction

	// Level match per pin, from the synchronised, buffer-gated input
	logic [NPINS-1:0] match;
	logic [NPINS-1:0] in_gated;
	logic [NPINS-1:0] buf_on;

	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			// A peripheral that takes the pin over also owns its input buffer
			buf_on[i] = periph_ovr_en[i] ? periph_in_en[i]
				: ~q.setup[i][`GPLS_SETUP_INDISC];
			in_gated[i] = pin_sync[i] & buf_on[i];
			// Level, not edge, so a level present at enable matches at once
			unique case (q.setup[i][`GPLS_SETUP_SNS_LSB +: 2])
				gpls_pkg::GPLS_SENSE_HIGH: match[i] = in_gated[i];
				gpls_pkg::GPLS_SENSE_LOW:  match[i] = ~pin_sync[i] & buf_on[i];
				default:                   match[i] = 1'b0;
			endcase
		end
	end

	always_comb begin
		rst_v = '0;
		for (int i = 0; i < NPINS; i++) begin
			rst_v.setup[i] = `GPLS_SETUP_RESET;
		end
		rst_v.awready = 1'b1;
		rst_v.wready  = 1'b1;
		rst_v.arready = 1'b1;
	end

	logic             wr_go;
	logic [31:0]      wmask;
	logic [31:0]      wbits;
	logic [NPINS-1:0] clr_bits;
	logic             clr_wr;
	logic             wr_hit;
	logic [31:0]      rd_val;
	logic             rd_hit;
	logic             det_src;

	always_comb begin
		d = q;
		wr_go    = q.aw_ok && q.w_ok && !q.bvalid;
		wmask    = strb_mask(q.w_strb);
		wbits    = q.w_data & wmask;
		clr_bits = '0;
		clr_wr   = 1'b0;
		wr_hit   = 1'b1;
		rd_val   = '0;
		rd_hit   = 1'b1;

		// Address and data are taken independently, in either order
		if (s_axi_awvalid && q.awready) begin
			d.aw_ok   = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_ok   = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end

		if (wr_go) begin
			unique case (q.aw_addr)
				`GPLS_OFF_OUT:    d.drv  = narrow((widen(q.drv) & ~wmask) | wbits);
				`GPLS_OFF_OUTSET: d.drv  = q.drv | narrow(wbits);
				`GPLS_OFF_OUTCLR: d.drv  = q.drv & ~narrow(wbits);
				`GPLS_OFF_DIR:    d.dir  = narrow((widen(q.dir) & ~wmask) | wbits);
				`GPLS_OFF_DIRSET: d.dir  = q.dir | narrow(wbits);
				`GPLS_OFF_DIRCLR: d.dir  = q.dir & ~narrow(wbits);
				`GPLS_OFF_IN:     wr_hit = 1'b1;
				`GPLS_OFF_LATCH: begin
					clr_bits = narrow(wbits);
					clr_wr   = 1'b1;
				end
				`GPLS_OFF_MODE: begin
					if (wmask[`GPLS_MODE_BIT]) begin
						d.mode = wbits[`GPLS_MODE_BIT];
					end
				end
				default: begin
					if (is_setup(q.aw_addr)) begin
						d.setup[setup_idx(q.aw_addr)] = ((q.setup[setup_idx(q.aw_addr)]
							& ~wmask) | wbits) & `GPLS_SETUP_MASK;
					end else begin
						wr_hit = 1'b0;
					end
				end
			endcase
			// A pin_setup write must reach DIR before DIR is copied back
			if (is_setup(q.aw_addr)) begin
				d.dir[setup_idx(q.aw_addr)] =
					d.setup[setup_idx(q.aw_addr)][`GPLS_SETUP_DIR];
			end
			// Direction written through DIR also tracks into the pin_setup copy
			for (int i = 0; i < NPINS; i++) begin
				d.setup[i][`GPLS_SETUP_DIR] = d.dir[i];
			end
			d.aw_ok  = 1'b0;
			d.w_ok   = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = wr_hit ? `GPLS_RESP_OKAY : `GPLS_RESP_SLVERR;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		d.awready = !d.aw_ok && !d.bvalid;
		d.wready  = !d.w_ok && !d.bvalid;

		// Read path answers one cycle after the address is taken
		if (s_axi_arvalid && q.arready) begin
			unique case (s_axi_araddr)
				`GPLS_OFF_OUT, `GPLS_OFF_OUTSET, `GPLS_OFF_OUTCLR: rd_val = widen(q.drv);
				`GPLS_OFF_DIR, `GPLS_OFF_DIRSET, `GPLS_OFF_DIRCLR: rd_val = widen(q.dir);
				`GPLS_OFF_IN:    rd_val = widen(q.in_v);
				`GPLS_OFF_LATCH: rd_val = widen(q.latch);
				`GPLS_OFF_MODE:  rd_val = 32'(q.mode);
				default: begin
					if (is_setup(s_axi_araddr)) begin
						rd_val = q.setup[setup_idx(s_axi_araddr)];
					end else begin
						rd_hit = 1'b0;
					end
				end
			endcase
			d.rdata   = rd_val;
			d.rresp   = rd_hit ? `GPLS_RESP_OKAY : `GPLS_RESP_SLVERR;
			d.rvalid  = 1'b1;
			d.arready = 1'b0;
		end
		if (q.rvalid && s_axi_rready) begin
			d.rvalid  = 1'b0;
			d.arready = 1'b1;
		end

		// Set wins over clear, and a still-matching pin re-sets at once
		d.latch = (q.latch & ~clr_bits) | match;
		// A clear that leaves bits standing dips the signal for one cycle
		d.latched = (|d.latch) && !(clr_wr && |(q.latch & clr_bits));

		det_src  = q.mode ? d.latched : |match;
		d.detect = det_src;
		d.wake_ev = det_src && !q.detect;
		d.wake_req = det_src && deep_sleep;

		d.in_v = in_gated;
		for (int i = 0; i < NPINS; i++) begin
			// Peripheral takeover of output value and pin configuration
			if (periph_ovr_en[i]) begin
				d.p_out[i] = periph_out[i];
				d.p_oe[i]  = periph_oe[i];
				d.p_ien[i] = periph_in_en[i];
			end else begin
				d.p_out[i] = d.drv[i];
				d.p_oe[i]  = d.setup[i][`GPLS_SETUP_DIR];
				d.p_ien[i] = !d.setup[i][`GPLS_SETUP_INDISC];
			end
			d.p_pu[i]  = d.setup[i][`GPLS_SETUP_PULL_LSB +: 2] == `GPLS_PULL_UP;
			d.p_pd[i]  = d.setup[i][`GPLS_SETUP_PULL_LSB +: 2] == `GPLS_PULL_DOWN;
			d.p_drv[i] = d.setup[i][`GPLS_SETUP_DRV_LSB +: 3];
		end
	end

	// pin_setup is retained storage: the bus reset leaves it untouched
	always_ff @(posedge aclk) begin
		if (!cfg_resetn) begin
			q <= rst_v;
		end else if (!aresetn) begin
			q       <= rst_v;
			q.setup <= q.setup;
			for (int i = 0; i < NPINS; i++) begin
				q.dir[i] <= q.setup[i][`GPLS_SETUP_DIR];
			end
		end else if (ce) begin
			q <= d;
		end
	end

	assign s_axi_awready        = q.awready;
	assign s_axi_wready         = q.wready;
	assign s_axi_bvalid         = q.bvalid;
	assign s_axi_bresp          = q.bresp;
	assign s_axi_arready        = q.arready;
	assign s_axi_rvalid         = q.rvalid;
	assign s_axi_rdata          = q.rdata;
	assign s_axi_rresp          = q.rresp;
	assign pin_out              = q.p_out;
	assign pin_oe               = q.p_oe;
	assign pin_pull_up          = q.p_pu;
	assign pin_pull_down        = q.p_pd;
	assign pin_in_en            = q.p_ien;
	assign pin_drive            = q.p_drv;
	assign periph_in            = q.in_v;
	assign detect               = q.detect;
	assign port_wake_event      = q.wake_ev;
	assign latched_match_signal = q.latched;
	assign wake_req             = q.wake_req;

endmodule

// File: gpls_port_props.sv
// Concurrent checks on the level-sense GPIO port
`timescale 1ns/1ps
module gpls_port_props #(
	parameter int NPINS = 32
) (
	input wire logic             aclk,
	input wire logic             aresetn,
	input wire logic             cfg_resetn,
	input wire logic             s_axi_awvalid,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_wvalid,
	input wire logic             s_axi_wready,
	input wire logic [1:0]       s_axi_bresp,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic [31:0]      s_axi_rdata,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic [NPINS-1:0] pin_in_en,
	input wire logic             deep_sleep,
	input wire logic             detect,
	input wire logic             port_wake_event,
	input wire logic             latched_match_signal,
	input wire logic             wake_req
);
	logic [3:0] quiet_q;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn || !cfg_resetn);
	// Cycles with every input buffer disconnected, saturating
	always_ff @(posedge aclk)
		if (!aresetn || !cfg_resetn || (|pin_in_en))
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response not on time");
	a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
		else $error("read response not on time");
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped early");
	a_wake_on_rise: assert property ($rose(detect) |-> ##[0:1] port_wake_event)
		else $error("detect rose without wake pulse");
	a_wake_one_cycle: assert property (port_wake_event |=> !port_wake_event)
		else $error("wake pulse too long");
	a_wake_req_src: assert property (wake_req |-> (detect || $past(detect)) && (deep_sleep || $past(deep_sleep)))
		else $error("wake request without detect in sleep");
	a_disc_no_detect: assert property (quiet_q > 4'h8 && !latched_match_signal && $past(!latched_match_signal) |-> !detect)
		else $error("detect from disconnected pins");
	a_latch_sw_only: assert property ($fell(latched_match_signal) |-> $rose(s_axi_bvalid))
		else $error("latched match fell without a write");
endmodule

bind gpls_port gpls_port_props #(.NPINS(NPINS)) gpls_port_props_i (.aclk(aclk), .aresetn(aresetn),
	.cfg_resetn(cfg_resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pin_in_en(pin_in_en), .deep_sleep(deep_sleep), .detect(detect),
	.port_wake_event(port_wake_event), .latched_match_signal(latched_match_signal),
	.wake_req(wake_req));

// File: gpls_pad_model.sv
// Pads with external circuitry: drive, pulls, or a floating pad
`timescale 1ns/1ps
module gpls_pad_model (
	input  wire logic        aclk,
	input  wire logic [31:0] pin_out,
	input  wire logic [31:0] pin_oe,
	input  wire logic [31:0] pin_pull_up,
	input  wire logic [31:0] pin_pull_down,
	input  wire logic [31:0] ext_en,
	input  wire logic [31:0] ext_val,
	output logic      [31:0] pad
);
	logic [31:0] last_q = 32'h0;
	always_ff @(posedge aclk)
		last_q <= pad;
	// Floating pad shows the inverse of its last level, never a stale value
	always_comb
		for (int i = 0; i < 32; i++)
			if (pin_oe[i])
				pad[i] = pin_out[i];
			else if (ext_en[i])
				pad[i] = ext_val[i];
			else if (pin_pull_up[i])
				pad[i] = 1'b1;
			else if (pin_pull_down[i])
				pad[i] = 1'b0;
			else
				pad[i] = ~last_q[i];
endmodule

// File: gpls_port_tb.sv
// Self-checking bench for the level-sense GPIO port
`timescale 1ns/1ps
`include "gpls_cfg.svh"
module gpls_port_tb;
	typedef struct {logic [1:0] sns; logic lvl; logic disc; logic exp;} gpls_row_s;
	logic        aclk = 0, aresetn = 0, cfg_resetn = 0, deep_sleep = 0, ce = 1;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, rd_v, pad, pout, poe, ppu, ppd, pien, p_in;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        awready, wready, bvalid, arready, rvalid, detect, wake_ev, latched, wake_req;
	logic [1:0]  bresp, rresp, rd_r;
	logic [31:0] ext_en = 32'h0, ext_val = 32'h0, ovr = 32'h0, p_out = 32'h0, p_oe = 32'h0;
	logic [31:0] p_ien = 32'h0;
	logic [95:0] drv;
	int          n_errors = 0, cmp_count = 0, n_wake = 0, w, p;
	gpls_row_s   rows [7] = '{'{2'h2, 1, 0, 1}, '{2'h2, 0, 0, 0}, '{2'h3, 0, 0, 1},
		'{2'h3, 1, 0, 0}, '{2'h0, 1, 0, 0}, '{2'h1, 1, 0, 0}, '{2'h2, 1, 1, 0}};

	gpls_port gpls_port_i (.aclk(aclk), .aresetn(aresetn), .cfg_resetn(cfg_resetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pin_in(pad), .pin_out(pout), .pin_oe(poe), .pin_pull_up(ppu), .pin_pull_down(ppd),
		.pin_in_en(pien), .pin_drive(drv), .periph_ovr_en(ovr), .periph_out(p_out),
		.periph_oe(p_oe), .periph_in_en(p_ien), .periph_in(p_in), .deep_sleep(deep_sleep),
		.detect(detect), .port_wake_event(wake_ev), .latched_match_signal(latched),
		.wake_req(wake_req));
	gpls_pad_model gpls_pad_model_i (.aclk(aclk), .pin_out(pout), .pin_oe(poe),
		.pin_pull_up(ppu), .pin_pull_down(ppd), .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

	always #20 aclk = ~aclk;
	always @(posedge aclk)
		if (wake_ev === 1'b1)
			n_wake <= n_wake + 1;

	task check(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
			n_errors++;
		end
	endtask
	// Response ready is raised one cycle after address and data are taken, on the same edge as the answer arrives
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (awvalid || wvalid);
		bready <= 1;
		do @(posedge aclk); while (!bvalid);
		bready <= 0;
	endtask
	task rd(input logic [11:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end while (arvalid);
		rready <= 1;
		do @(posedge aclk); while (!rvalid);
		rd_v = rdata;
		rd_r = rresp;
		rready <= 0;
	endtask
	task settle(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task done(input string s);
		$display("test %s finished", s);
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		settle(20000);
		n_errors++;
		stop_test;
	end

	initial begin
		settle(12);
		aresetn <= 1;
		cfg_resetn <= 1;
		rd(`GPLS_OFF_SETUP);
		check(rd_v, 32'h2);
		check(poe, 32'h0);
		rd(12'h600);
		check({30'h0, rd_r}, 32'h2);
		done("reset");
		foreach (rows[i]) begin
			p = 4 * i + 3;
			ext_en[p] <= 1;
			ext_val[p] <= rows[i].lvl;
			settle(8);
			w = n_wake;
			wr(`GPLS_OFF_SETUP + 12'(4 * p), {14'h0, rows[i].sns, 14'h0, rows[i].disc, 1'b0});
			settle(8);
			check(detect, rows[i].exp);
			check(n_wake - w, rows[i].exp);
			rd(`GPLS_OFF_IN);
			check(rd_v[p], rows[i].lvl & ~rows[i].disc);
			rd(`GPLS_OFF_LATCH);
			check(rd_v[p], rows[i].exp);
			wr(`GPLS_OFF_SETUP + 12'(4 * p), 32'h2);
			wr(`GPLS_OFF_LATCH, 32'hffffffff);
			ext_en[p] <= 0;
		end
		done("table");
		// Pins parked at a non-matching level before sensing is enabled
		ext_en[3] <= 1;
		ext_val[3] <= 0;
		ext_en[5] <= 1;
		ext_val[5] <= 0;
		deep_sleep <= 1;
		settle(8);
		wr(`GPLS_OFF_SETUP + 12'h00c, 32'h00020000);
		wr(`GPLS_OFF_SETUP + 12'h014, 32'h00020000);
		ext_val[3] <= 1;
		ext_val[5] <= 1;
		settle(8);
		ext_val[3] <= 0;
		settle(8);
		rd(`GPLS_OFF_LATCH);
		check(rd_v, 32'h28);
		wr(`GPLS_OFF_MODE, 32'h1);
		settle(4);
		w = n_wake;
		wr(`GPLS_OFF_LATCH, 32'hffffffff);
		settle(4);
		rd(`GPLS_OFF_LATCH);
		check(rd_v, 32'h20);
		check(latched, 1'b1);
		check(n_wake - w, 1);
		check(wake_req, 1'b1);
		wr(`GPLS_OFF_SETUP + 12'h014, 32'h2);
		wr(`GPLS_OFF_LATCH, 32'hffffffff);
		settle(4);
		check(latched, 1'b0);
		check(detect, 1'b0);
		deep_sleep <= 0;
		wr(`GPLS_OFF_MODE, 32'h0);
		done("sticky");
		ovr[7] <= 1;
		p_out[7] <= 1;
		p_oe[7] <= 1;
		p_ien[7] <= 1;
		settle(8);
		check({poe[7], pout[7], p_in[7]}, 3'h7);
		ovr[7] <= 0;
		done("override");
		// Frozen clock enable must hide a matching level until released
		ce <= 0;
		ext_val[3] <= 1;
		settle(8);
		check(detect, 1'b0);
		ce <= 1;
		settle(8);
		check(detect, 1'b1);
		ext_val[3] <= 0;
		settle(8);
		wr(`GPLS_OFF_LATCH, 32'hffffffff);
		done("enable");
		wr(`GPLS_OFF_SETUP + 12'h024, 32'h0000070d);
		aresetn <= 0;
		settle(2);
		aresetn <= 1;
		rd(`GPLS_OFF_SETUP + 12'h024);
		check(rd_v, 32'h70d);
		check({poe[9], ppu[9], drv[29:27]}, 5'h1f);
		cfg_resetn <= 0;
		settle(2);
		cfg_resetn <= 1;
		rd(`GPLS_OFF_SETUP + 12'h024);
		check(rd_v, 32'h2);
		done("retention");
		stop_test;
	end
endmodule
